// ==== capture_compare_unit_test.sv ====
// Purpose: self-checking bench for the capture/compare unit
// Assumes: timer stopped and loaded by the bench around captures
// Notes: expected values come from the mode table, not the design
`timescale 1ns/10ps
module capture_compare_unit_test;
    import ccu_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic adc_enabled = 1'b0;
    logic run = 1'b0;
    logic load = 1'b0;
    logic level = 1'b0;
    logic [15:0] load_val = 16'h0000;
    logic [7:0] reg_rdata;
    logic [15:0] timer_count;
    logic timer_tick, timer_reset, event_pin, special_event;
    logic adc_start, unit_interrupt_flag, sev_seen;
    ccu_pins_t pins;
    ccu_pwm_cfg_t pwm_cfg;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] cmp_mode [4] = '{8'h02, 8'h09, 8'h08, 8'h0a};
    logic cmp_out [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    always #50 clk = ~clk;
    ccu_event_src u_src (.clk(clk), .rst_b(rst_b), .run(run), .load(load),
        .load_val(load_val), .level(level), .timer_reset(timer_reset),
        .timer_count(timer_count), .timer_tick(timer_tick),
        .event_pin(event_pin));
    ccu_unit u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer_count(timer_count),
        .timer_tick(timer_tick), .adc_enabled(adc_enabled),
        .event_pin(event_pin), .timer_reset(timer_reset),
        .special_event(special_event), .adc_start(adc_start),
        .unit_interrupt_flag(unit_interrupt_flag), .pins(pins),
        .pwm_cfg(pwm_cfg));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk({8'h00, reg_rdata}, {8'h00, e});
    endtask
    task automatic flag_is(input logic v);
        @(negedge clk);
        chk({15'h0, unit_interrupt_flag}, {15'h0, v});
    endtask
    // pin change, then room for the synchroniser and the capture
    task automatic pin(input logic v);
        @(posedge clk);
        level <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic edges(input int n);
        repeat (n) begin
            pin(1'b1);
            pin(1'b0);
        end
    endtask
    task automatic timer_at(input logic [15:0] v);
        @(posedge clk);
        load <= 1'b1;
        load_val <= v;
        @(posedge clk);
        load <= 1'b0;
    endtask
    // off first so the prescaler restarts, then drop any stray flag
    task automatic set_mode(input logic [7:0] m);
        wr(2'h0, 8'h00);
        wr(2'h0, m);
        repeat (6) @(posedge clk);
        wr(2'h3, 8'h00);
    endtask
    // timer sweeps 1230..123a, passing the compare value once
    task automatic cmp_run();
        timer_at(16'h1230);
        run <= 1'b1;
        repeat (10) @(posedge clk);
        run <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    // hang guard, well above the several hundred cycles of the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(2'h0, 8'h00);
        rd(2'h3, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(2'h0, 8'hec | 8'(i));
            rd(2'h0, 8'hac | 8'(i));
            chk({10'h0, pwm_cfg}, {10'h0, 4'hc | 4'(i), 2'h2});
            chk({15'h0, pins.secondary_is_port}, 16'h0000);
        end
        wr(2'h0, 8'hb4);
        @(negedge clk);
        chk({10'h0, pwm_cfg}, 16'h0000);
        chk({15'h0, pins.secondary_is_port}, 16'h0001);
        set_mode(8'h05);
        timer_at(16'h4321);
        pin(1'b1);
        flag_is(1'b1);
        rd(2'h1, 8'h21);
        rd(2'h2, 8'h43);
        pin(1'b0);
        timer_at(16'h5678);
        pin(1'b1);
        rd(2'h1, 8'h78);
        rd(2'h2, 8'h56);
        pin(1'b0);
        set_mode(8'h04);
        pin(1'b1);
        flag_is(1'b0);
        pin(1'b0);
        flag_is(1'b1);
        set_mode(8'h06);
        edges(2);
        set_mode(8'h06);
        edges(3);
        flag_is(1'b0);
        edges(1);
        flag_is(1'b1);
        set_mode(8'h07);
        edges(15);
        flag_is(1'b0);
        edges(1);
        flag_is(1'b1);
        wr(2'h1, 8'h34);
        wr(2'h2, 8'h12);
        for (int i = 0; i < 4; i++) begin
            wr(2'h0, cmp_mode[i]);
            wr(2'h3, 8'h00);
            cmp_run();
            chk({15'h0, pins.primary_out}, {15'h0, cmp_out[i]});
            chk({15'h0, unit_interrupt_flag}, 16'h0001);
        end
        wr(2'h0, 8'h00);
        // latch follows the cleared control one edge later
        repeat (2) @(negedge clk);
        chk({15'h0, pins.primary_out}, 16'h0000);
        @(posedge clk);
        adc_enabled <= 1'b1;
        wr(2'h0, 8'h0b);
        wr(2'h3, 8'h00);
        sev_seen = 1'b0;
        timer_at(16'h1230);
        run <= 1'b1;
        for (int i = 0; i < 20 && !sev_seen; i++) begin
            @(negedge clk);
            if (special_event === 1'b1) begin
                sev_seen = 1'b1;
                chk({15'h0, adc_start}, 16'h0001);
            end
        end
        @(posedge clk);
        @(negedge clk);
        chk({15'h0, sev_seen}, 16'h0001);
        chk(timer_count, 16'h0000);
        @(posedge clk);
        run <= 1'b0;
        flag_is(1'b1);
        // match with the timer stopped: reset waits for the next tick
        timer_at(16'h1234);
        rd(2'h3, 8'h09);
        chk(timer_count, 16'h1234);
        @(posedge clk);
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        @(negedge clk);
        chk(timer_count, 16'h0000);
        // match removed before the tick, so no reset follows
        timer_at(16'h1234);
        wr(2'h1, 8'h40);
        rd(2'h3, 8'h01);
        @(posedge clk);
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        @(negedge clk);
        chk(timer_count, 16'h1235);
        end_of_test();
    end
endmodule // capture_compare_unit_test

// ==== ccu_consts.svh ====
// Purpose: offsets, field positions, reset values for the capture/compare unit
// Assumes: byte-wide register port, two address bits
// Notes: definitions only
`ifndef CCU_CONSTS_SVH
`define CCU_CONSTS_SVH

// register offsets on the plain register port
`define CCU_OFS_CONTROL 2'h0
`define CCU_OFS_LOW 2'h1
`define CCU_OFS_HIGH 2'h2
`define CCU_OFS_STATUS 2'h3

// reset values and the control write mask
`define CCU_CONTROL_RST 8'h00
`define CCU_CONTROL_WMASK 8'hbf
`define CCU_VALUE_RST 16'h0000

// status register bit positions
`define CCU_ST_FLAG 0
`define CCU_ST_OUT 1
`define CCU_ST_PIN 2
`define CCU_ST_PEND 3

// prescaler last counts for 1, 4 and 16 edges
`define CCU_PS_LAST_1 4'h0
`define CCU_PS_LAST_4 4'h3
`define CCU_PS_LAST_16 4'hf

`endif

// ==== ccu_event_src.sv ====
// Purpose: timer and event pin source beside the capture/compare unit
// Assumes: timer clocked by the system clock, one tick per running cycle
// Notes: timer can be stopped and loaded so captures are predictable
`timescale 1ns/10ps
module ccu_event_src (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic level,
    input wire logic timer_reset,
    output logic [15:0] timer_count,
    output logic timer_tick,
    output logic event_pin
);
    // synchronous counting, so captures never race the timer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) timer_count <= 16'h0000;
        else if (load) timer_count <= load_val;
        else if (timer_reset) timer_count <= 16'h0000;
        else if (run) timer_count <= timer_count + 16'h0001;
    end
    assign timer_tick = run; // stopped timer gives no ticks
    assign event_pin = level; // the pin level itself
endmodule // ccu_event_src

// ==== ccu_pkg.sv ====
// Purpose: types shared by the capture/compare unit and its users
// Assumes: nothing beyond the constants header
// Notes: mode codes are those of the control register's low nibble
package ccu_pkg;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic output_config_select;
        logic unused6;
        logic [1:0] duty_low_bits;
        logic [3:0] unit_mode_select;
    } ccu_ctrl_t;

    typedef enum logic [3:0] {
        CCU_OFF = 4'b0000,
        CCU_RSV1 = 4'b0001,
        CCU_CMP_TOGGLE = 4'b0010,
        CCU_RSV3 = 4'b0011,
        CCU_CAP_FALL = 4'b0100,
        CCU_CAP_RISE = 4'b0101,
        CCU_CAP_RISE4 = 4'b0110,
        CCU_CAP_RISE16 = 4'b0111,
        CCU_CMP_SET = 4'b1000,
        CCU_CMP_CLEAR = 4'b1001,
        CCU_CMP_SOFT = 4'b1010,
        CCU_CMP_SPECIAL = 4'b1011,
        CCU_PWM_HH = 4'b1100,
        CCU_PWM_HL = 4'b1101,
        CCU_PWM_LH = 4'b1110,
        CCU_PWM_LL = 4'b1111
    } ccu_mode_t;

    // settings handed to the external waveform generator
    typedef struct packed {
        logic pwm_active;
        logic half_bridge;
        logic primary_active_low;
        logic secondary_active_low;
        logic [1:0] duty_low_bits;
    } ccu_pwm_cfg_t;

    // pin control for the primary and secondary pins
    typedef struct packed {
        logic primary_out;
        logic primary_oe;
        logic secondary_is_port;
    } ccu_pins_t;

endpackage

// ==== ccu_unit.sv ====
// Purpose: capture and compare unit driven by a 16-bit timer count
// Assumes: timer and converter outside; timer_tick marks timer clock rise
// Notes: waveform generator is outside; only its settings leave here
//   register map on the byte port, two address bits:
//   0 control: bit 7 output config, 6 unused, 5:4 duty low, 3:0 mode
//   1 value low byte, 2 value high byte
//   3 status: bit 0 flag (write sets or clears), bit 1 output latch,
//     bit 2 filtered pin level, bit 3 timer reset pending, rest zero
//   read data stand one cycle after the read strobe, zero otherwise
//   a capture in the same cycle as a value byte write wins over it
//   the hardware flag set wins over a software clear in one cycle
//   the value pair resets to zero so reads are never unknown
//   a compare match acts once, on the cycle the match begins
//   reserved codes release the pin but keep the output latch
//   pin edges reach the capture four cycles after the pin moves
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "ccu_consts.svh"

module ccu_unit (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] timer_count,
    input wire logic timer_tick,
    input wire logic adc_enabled,
    input wire logic event_pin,
    output logic timer_reset,
    output logic special_event,
    output logic adc_start,
    output logic unit_interrupt_flag,
    output ccu_pkg::ccu_pins_t pins,
    output ccu_pkg::ccu_pwm_cfg_t pwm_cfg
);
    import ccu_pkg::*;

    // mode class decoders, used in several places
    function automatic logic is_capture(input logic [3:0] m);
        is_capture = (m[3:2] == 2'b01);
    endfunction

    function automatic logic is_compare(input logic [3:0] m);
        is_compare = (m == CCU_CMP_TOGGLE) || (m[3:2] == 2'b10);
    endfunction

    // last prescaler count for the selected rising-edge capture mode
    function automatic logic [3:0] ps_last(input logic [3:0] m);
        if (m == CCU_CAP_RISE4) begin
            ps_last = `CCU_PS_LAST_4;
        end else if (m == CCU_CAP_RISE16) begin
            ps_last = `CCU_PS_LAST_16;
        end else begin
            ps_last = `CCU_PS_LAST_1;
        end
    endfunction

    ccu_ctrl_t ctrl;
    logic [15:0] value;
    logic flag;
    logic out_latch;
    logic [3:0] ps_count;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic pin_level;
    logic pin_prev;
    logic match_prev;
    logic reset_pending;

    // register port decode
    wire wr_control = reg_wr && (reg_addr == `CCU_OFS_CONTROL);
    wire wr_low = reg_wr && (reg_addr == `CCU_OFS_LOW);
    wire wr_high = reg_wr && (reg_addr == `CCU_OFS_HIGH);
    wire wr_status = reg_wr && (reg_addr == `CCU_OFS_STATUS);

    // mode decode
    wire [3:0] mode = ctrl.unit_mode_select;
    wire unit_off = (mode == CCU_OFF);
    wire cap_mode = is_capture(mode);
    wire cmp_mode = is_compare(mode);
    wire pwm_mode = (mode[3:2] == 2'b11);

    // edges of the filtered pin level, one cycle each
    wire rise = pin_level && !pin_prev;
    wire fall = !pin_level && pin_prev;

    // qualified capture event after edge select and prescale
    wire counted_edge = (mode != CCU_CAP_FALL) && rise;
    wire ps_hit = (ps_count == ps_last(mode));
    wire capture_event = cap_mode &&
        (((mode == CCU_CAP_FALL) && fall) || (counted_edge && ps_hit));

    // compare runs every cycle; act once on the cycle a match begins
    wire match_now = (timer_count == value);
    wire match_event = cmp_mode && match_now && !match_prev;
    wire special_hit = match_event && (mode == CCU_CMP_SPECIAL);

    // flag: hardware set wins over a software clear in the same cycle
    wire hw_set = capture_event || match_event;
    wire next_flag = hw_set ? 1'b1 :
        (wr_status ? reg_wdata[`CCU_ST_FLAG] : flag);

    // compare output latch actions
    logic next_out;
    always_comb begin
        next_out = out_latch;
        if (unit_off) begin
            next_out = 1'b0;
        end else if (match_event) begin
            unique case (mode)
                CCU_CMP_TOGGLE: next_out = !out_latch;
                CCU_CMP_SET: next_out = 1'b1;
                CCU_CMP_CLEAR: next_out = 1'b0;
                default: next_out = out_latch; // soft and special
            endcase
        end
    end

    // read mux; unmapped bits and bit 6 read zero
    wire [7:0] status_word = {4'h0, reset_pending, pin_level, out_latch,
        flag};
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            `CCU_OFS_CONTROL: rd_mux = ctrl & `CCU_CONTROL_WMASK;
            `CCU_OFS_LOW: rd_mux = value[7:0];
            `CCU_OFS_HIGH: rd_mux = value[15:8];
            `CCU_OFS_STATUS: rd_mux = status_word;
        endcase
    end

    // control register; bit 6 is not stored
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= `CCU_CONTROL_RST;
        end else if (wr_control) begin
            ctrl <= reg_wdata & `CCU_CONTROL_WMASK;
        end
    end

    // value pair: capture loads both bytes at once and overwrites
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            value <= `CCU_VALUE_RST;
        end else if (capture_event) begin
            value <= timer_count;
        end else if (wr_low) begin
            value[7:0] <= reg_wdata;
        end else if (wr_high) begin
            value[15:8] <= reg_wdata;
        end
    end

    // interrupt flag, never cleared by hardware
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    // compare output latch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_latch <= 1'b0;
        end else begin
            out_latch <= next_out;
        end
    end

    // edge prescaler; a prescale change keeps the count on purpose
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ps_count <= 4'h0;
        end else if (!cap_mode) begin
            ps_count <= 4'h0;
        end else if (counted_edge) begin
            ps_count <= ps_hit ? 4'h0 : ps_count + 4'h1;
        end
    end

    // three-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end else begin
            pin_s1 <= event_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // level accepted once stages two and three agree, glitch filter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_level <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            if (pin_s2 == pin_s3) begin
                pin_level <= pin_s3;
            end
            pin_prev <= pin_level;
        end
    end

    // match history; cleared when off so a stale match is not held
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            match_prev <= 1'b0;
        end else if (!cmp_mode) begin
            match_prev <= 1'b0;
        end else begin
            match_prev <= match_now;
        end
    end

    // timer reset waits for the timer tick and drops if the match goes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_pending <= 1'b0;
        end else if (mode != CCU_CMP_SPECIAL || !match_now) begin
            reset_pending <= 1'b0; // cancel on lost match
        end else if (special_hit) begin
            reset_pending <= !timer_tick;
        end else if (timer_tick) begin
            reset_pending <= 1'b0;
        end
    end

    // registered read data, valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // trigger leaves at once; converter start only when enabled
    // no path here reaches the timer overflow flag
    assign special_event = special_hit;
    assign adc_start = special_hit && adc_enabled;
    // timer reset lands on the tick with the match still present
    assign timer_reset = timer_tick && match_now &&
        (mode == CCU_CMP_SPECIAL) &&
        (reset_pending || special_hit);
    assign unit_interrupt_flag = flag;

    // pin control: soft and special modes leave the pin alone
    assign pins.primary_out = out_latch;
    assign pins.primary_oe = cmp_mode && (mode != CCU_CMP_SOFT) &&
        (mode != CCU_CMP_SPECIAL);
    assign pins.secondary_is_port = !(pwm_mode &&
        ctrl.output_config_select);

    // waveform settings; meaningless outside PWM so held at zero
    assign pwm_cfg.pwm_active = pwm_mode;
    assign pwm_cfg.half_bridge = pwm_mode &&
        ctrl.output_config_select;
    assign pwm_cfg.primary_active_low = pwm_mode && mode[1];
    assign pwm_cfg.secondary_active_low = pwm_mode && mode[0];
    assign pwm_cfg.duty_low_bits = pwm_mode ? ctrl.duty_low_bits :
        2'b00;

endmodule // ccu_unit

// ==== ccu_unit_checker.sv ====
// Purpose: port-level checks for the capture/compare unit
// Assumes: control register changes only through the register port
// Notes: a mirror of the control register is kept as helper state
`timescale 1ns/10ps
module ccu_unit_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic adc_enabled,
    input wire logic timer_tick,
    input wire logic timer_reset,
    input wire logic special_event,
    input wire logic adc_start,
    input wire logic unit_interrupt_flag,
    input wire ccu_pkg::ccu_pins_t pins,
    input wire ccu_pkg::ccu_pwm_cfg_t pwm_cfg
);
    import ccu_pkg::*;
    logic [7:0] ctrl;
    logic pwm;
    logic flag_clr;
    // mirror of control; bit 6 is never stored
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) ctrl <= 8'h00;
        else if (reg_wr && reg_addr == 2'h0) ctrl <= reg_wdata & 8'hbf;
    end
    assign pwm = ctrl[3:2] == 2'b11;
    assign flag_clr = reg_wr && reg_addr == 2'h3 && !reg_wdata[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence ctrl_off;
        reg_wr && reg_addr == 2'h0 && reg_wdata[3:0] == 4'h0;
    endsequence
    sequence sev_pulse;
        special_event ##1 !special_event;
    endsequence
    AST_ADC_START: assert property (
        adc_start == (special_event && adc_enabled))
        else $error("adc start not tied to special event");
    AST_SEV_MODE: assert property (
        special_event |-> ctrl[3:0] == 4'hb)
        else $error("special event outside its mode");
    AST_SEV_FLAG: assert property (
        special_event |=> unit_interrupt_flag)
        else $error("match did not raise the flag");
    AST_SEV_ONCE: assert property (special_event |-> sev_pulse)
        else $error("special event longer than one cycle");
    AST_TRST: assert property (
        timer_reset |-> timer_tick && ctrl[3:0] == 4'hb)
        else $error("timer reset off its tick");
    AST_FLAG_KEEP: assert property (
        $fell(unit_interrupt_flag) |-> $past(flag_clr))
        else $error("flag cleared without software");
    // control lands one edge after the strobe, the latch one edge later
    AST_LATCH_LOW: assert property (
        ctrl_off |-> ##2 !pins.primary_out)
        else $error("output latch not low after off");
    AST_OE: assert property (
        pins.primary_oe == (ctrl[3:0] inside {4'h2, 4'h8, 4'h9}))
        else $error("pin drive wrong for mode");
    AST_PWM_CFG: assert property (
        pwm_cfg == (pwm ? {1'b1, ctrl[7], ctrl[1:0], ctrl[5:4]} : 6'h00))
        else $error("waveform settings wrong");
    AST_PORT_PIN: assert property (
        pins.secondary_is_port == !(pwm && ctrl[7]))
        else $error("secondary pin role wrong");
endmodule // ccu_unit_checker
bind ccu_unit ccu_unit_checker u_chk (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .adc_enabled(adc_enabled), .timer_tick(timer_tick),
    .timer_reset(timer_reset), .special_event(special_event),
    .adc_start(adc_start), .unit_interrupt_flag(unit_interrupt_flag),
    .pins(pins), .pwm_cfg(pwm_cfg));
